// [logic/arbiter_defs.vh]
`ifndef ARBITER_DEFS_VH
`define ARBITER_DEFS_VH
`define PRIO_DEFAULT 16'h0000
`define PRIO_DMA_HIGH 16'h0020
`define PRIO_RESET 16'h0000
`define DMA_HIGH_RESET 1'b0
`define IDX_CORE 2'h0
`define IDX_DMA 2'h1
`define IDX_DEBUG 2'h2
`define NUM_MASTERS 3
`endif

// [logic/prio_picker.v]
`timescale 1ns/1ps
`include "arbiter_defs.vh"
module prio_picker #(
	parameter N = 3
) (
	req,
	rank0,
	rank1,
	rank2,
	onehot
);
	input wire [N-1:0] req;
	input wire [1:0] rank0;
	input wire [1:0] rank1;
	input wire [1:0] rank2;
	output reg [N-1:0] onehot;
	reg [1:0] r [0:2];
	integer i;
	always @* begin
		r[0] = rank0;
		r[1] = rank1;
		r[2] = rank2;
		onehot = {N{1'b0}};
		// walk ranks from lowest (slot 2) up to slot 0; last requester found, the highest ranked, wins
		for (i = 2; i >= 0; i = i - 1) begin
			if (req[r[i]])
				onehot = {N{1'b0}} | ({{(N-1){1'b0}}, 1'b1} << r[i]);
		end
	end
endmodule

// [logic/data_memory_bus_arbiter.v]
`timescale 1ns/1ps
`include "arbiter_defs.vh"
// Behaviour
// - arbitrate core, dma, debug for data space
// - grant highest requester, hold others pending
// - default order core, dma, debug
// - reserved levels m1, m2 stay empty
// - 0x0020 puts dma above core
// - raised masters keep mutual order
// - lower masters keep original relative order
// - priority change accepted any time
module data_memory_bus_arbiter (
	ref_clk,
	rst,
	core_req,
	dma_req,
	debug_unit_master_req,
	core_done,
	dma_done,
	debug_unit_master_done,
	master_priority_ctrl,
	core_gnt,
	dma_gnt,
	debug_unit_master_gnt,
	bus_busy,
	dma_high
);
	input wire ref_clk;
	input wire rst;
	input wire core_req;
	input wire dma_req;
	input wire debug_unit_master_req;
	input wire core_done;
	input wire dma_done;
	input wire debug_unit_master_done;
	input wire [15:0] master_priority_ctrl;
	output wire core_gnt;
	output wire dma_gnt;
	output wire debug_unit_master_gnt;
	output wire bus_busy;
	output wire dma_high;

	////////////////////////////////////////////////////////////////////
	localparam ST_ARB = 1'b0;

	localparam ST_OWN = 1'b1;

	localparam NM = `NUM_MASTERS;

	reg state_r;

	reg state_nxt;

	reg dma_high_r;

	reg dma_high_nxt;

	reg [NM-1:0] gnt_r;

	reg [NM-1:0] gnt_nxt;

	wire [NM-1:0] req;

	wire [NM-1:0] done;

	wire [NM-1:0] pend;

	wire [NM-1:0] pick;

	wire [NM-1:0] owner_done;

	wire [1:0] rank0;

	wire [1:0] rank1;

	wire [1:0] rank2;

	wire set_default;

	wire set_dma_high;

	wire any_done;

	wire any_pick;

	genvar k;

	////////////////////////////////////////////////////////////////////
	// masters sit on this clock, so no synchroniser

	assign req[`IDX_CORE] = core_req;

	assign req[`IDX_DMA] = dma_req;

	assign req[`IDX_DEBUG] = debug_unit_master_req;

	assign done[`IDX_CORE] = core_done;

	assign done[`IDX_DMA] = dma_done;

	assign done[`IDX_DEBUG] = debug_unit_master_done;

	////////////////////////////////////////////////////////////////////
	// only the two legal words move the ranking

	assign set_default = (master_priority_ctrl == `PRIO_DEFAULT);

	assign set_dma_high = (master_priority_ctrl == `PRIO_DMA_HIGH);

	// reserved settings keep the last legal ranking rather than guessing
	always @* begin
		dma_high_nxt = dma_high_r;

		if (set_dma_high) begin
			dma_high_nxt = 1'b1;
		end else if (set_default) begin
			dma_high_nxt = 1'b0;
		end
	end

	// used from the next arbitration on, never preempts an owner
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dma_high_r <= `DMA_HIGH_RESET;
		end else begin
			dma_high_r <= dma_high_nxt;
		end
	end

	assign dma_high = dma_high_r;

	////////////////////////////////////////////////////////////////////
	// levels m1/m2 hold nobody, so only three slots exist

	assign rank0 = dma_high_r ? `IDX_DMA : `IDX_CORE;

	assign rank1 = dma_high_r ? `IDX_CORE : `IDX_DMA;

	assign rank2 = `IDX_DEBUG;

	prio_picker #(
		.N(NM)
	) u_prio_picker (
		.req(pend),
		.rank0(rank0),
		.rank1(rank1),
		.rank2(rank2),
		.onehot(pick)
	);

	////////////////////////////////////////////////////////////////////
	// per master: pending request and release by its own done

	generate
		for (k = 0; k < NM; k = k + 1) begin : g_master
			assign pend[k] = req[k] & ~gnt_r[k];

			assign owner_done[k] = gnt_r[k] & done[k];
		end
	endgenerate

	assign any_done = |owner_done;

	assign any_pick = |pick;

	////////////////////////////////////////////////////////////////////
	// owner keeps the bus until done; losers stay pending on req
	always @* begin
		state_nxt = state_r;

		gnt_nxt = gnt_r;

		case (state_r)
		ST_ARB: begin
			if (any_pick) begin
				state_nxt = ST_OWN;

				gnt_nxt = pick;
			end
		end

		ST_OWN: begin
			// done of a non-owner is masked out above
			if (any_done) begin
				state_nxt = ST_ARB;

				gnt_nxt = {NM{1'b0}};
			end
		end

		default: begin
			state_nxt = ST_ARB;

			gnt_nxt = {NM{1'b0}};
		end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_ARB;

			gnt_r <= {NM{1'b0}};
		end else begin
			state_r <= state_nxt;

			gnt_r <= gnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// one idle cycle after release costs bandwidth but keeps it simple

	assign core_gnt = gnt_r[`IDX_CORE];

	assign dma_gnt = gnt_r[`IDX_DMA];

	assign debug_unit_master_gnt = gnt_r[`IDX_DEBUG];

	assign bus_busy = |gnt_r;

endmodule

// [sim/arb_chk_checker.sv]
`timescale 1ns/1ps
module arb_chk(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic core_req,
	input wire logic dma_req,
	input wire logic debug_unit_master_req,
	input wire logic core_done,
	input wire logic dma_done,
	input wire logic debug_unit_master_done,
	input wire logic [15:0] master_priority_ctrl,
	input wire logic core_gnt,
	input wire logic dma_gnt,
	input wire logic debug_unit_master_gnt,
	input wire logic bus_busy,
	input wire logic dma_high
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
sequence s_owner_done;
	(core_gnt && core_done) || (dma_gnt && dma_done) ||
	(debug_unit_master_gnt && debug_unit_master_done);
endsequence
sequence s_owner_busy;
	bus_busy && !(core_gnt && core_done) && !(dma_gnt && dma_done) &&
	!(debug_unit_master_gnt && debug_unit_master_done);
endsequence
property p_hold;
	s_owner_busy |=> $stable({core_gnt, dma_gnt, debug_unit_master_gnt});
endproperty
a_hold: assert property (p_hold) else $error("owner lost bus");
property p_release; s_owner_done |=> !bus_busy; endproperty
a_release: assert property (p_release) else $error("no release");
property p_debug;
	!bus_busy && debug_unit_master_req && !core_req && !dma_req
	|=> debug_unit_master_gnt;
endproperty
a_debug: assert property (p_debug) else $error("debug");
property p_set_high; master_priority_ctrl == 16'h0020 |=> dma_high;
endproperty
a_set_high: assert property (p_set_high) else $error("high");
property p_set_default; master_priority_ctrl == 16'h0000 |=> !dma_high;
endproperty
a_set_default: assert property (p_set_default) else $error("dflt");
property p_one; $onehot0({core_gnt, dma_gnt, debug_unit_master_gnt});
endproperty
a_one: assert property (p_one) else $error("grants");
property p_core; !bus_busy && core_req && !dma_high |=> core_gnt; endproperty
a_core: assert property (p_core) else $error("core");
property p_dma; !bus_busy && dma_req && dma_high |=> dma_gnt; endproperty
a_dma: assert property (p_dma) else $error("dma");
endmodule

// [sim/master_model.sv]
`timescale 1ns/1ps
module master_model(input wire logic ref_clk, go, gnt, output logic req = 0,
output logic done = 0);
// raises done one cycle after the grant, so each ownership lasts two cycles
always @(posedge ref_clk) begin
	done <= gnt & ~done;
	if (done) req <= 1'h0;
	else if (go) req <= 1'h1;
end
endmodule

// [sim/data_memory_bus_arbiter_tb_top.sv]
`timescale 1ns/1ps
module data_memory_bus_arbiter_tb_top;
logic ref_clk = 0, rst = 1, b, h;
logic [2:0] go = 0, r, d, g;
logic [15:0] p = 0;
int n_fail = 0, n_tests = 0;
data_memory_bus_arbiter u_data_memory_bus_arbiter(.ref_clk(ref_clk),
.rst(rst), .core_req(r[0]), .dma_req(r[1]), .debug_unit_master_req(r[2]),
.core_done(d[0]), .dma_done(d[1]), .debug_unit_master_done(d[2]),
.master_priority_ctrl(p), .core_gnt(g[0]), .dma_gnt(g[1]),
.debug_unit_master_gnt(g[2]), .bus_busy(b), .dma_high(h));
master_model u_master_model[2:0](.ref_clk(ref_clk), .go(go), .gnt(g),
.req(r), .done(d));
initial forever #25 ref_clk = ~ref_clk;
task chk(input logic [8:0] s, e);
	n_tests++;
	if (s !== e) begin
		n_fail++;
		$display("[FAIL] %0t %h %h", $time, s, e);
	end
endtask
task finish_test;
	$display("%0d %0d", n_tests, n_fail);
	if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
// all three collide; grant order logged
task arb(input logic [15:0] v, input logic [8:0] e, input logic eh);
	logic [8:0] s;
	s = 9'h000;
	p = v;
	go = 3'h7;
	@(negedge ref_clk);
	go = 3'h0;
	repeat (30) begin
		@(negedge ref_clk);
		if (g != 3'h0 && g != s[2:0]) s = {s[5:0], g};
	end
	chk(s, e);
	chk({8'h00, h}, {8'h00, eh});
	chk({8'h00, b}, 9'h000);
endtask
initial begin
	repeat (5) @(negedge ref_clk);
	rst = 0;
	arb(16'h0000, 9'h054, 1'b0);
	arb(16'h0020, 9'h08C, 1'b1);
	arb(16'h0020, 9'h08C, 1'b1);
	arb(16'h0000, 9'h054, 1'b0);
	finish_test;
end
endmodule
bind data_memory_bus_arbiter arb_chk u_arb_chk(.*);
